/* File: rtl/txs_exec.sv */
// Execution unit: table write, test-zero-skip, xor ops, extension gating.
// Assumes one instruction word per four clocks, presented with instr_valid_i
// in phase 1; file data is returned combinationally by the register file.
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
module txs_exec #(
  parameter int PTR_W = txs_pkg::TXS_PTR_W,
  parameter int HOLD_N = txs_pkg::TXS_HOLD_N
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Instruction stream
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic extension_enable_bit_i,
  // Core state
  input wire logic [7:0] table_latch_i,
  input wire logic [7:0] file_data_i,
  input wire logic [3:0] bank_select_reg_i,
  // Results
  output logic [PTR_W-1:0] table_pointer_o,
  output logic [7:0] wreg_o,
  output logic flag_n_o,
  output logic flag_z_o,
  output logic [11:0] file_addr_o,
  output logic file_indexed_o,
  output logic file_we_o,
  output logic [7:0] file_wdata_o,
  output logic discard_o,
  output logic [1:0] ext_ptr_sel_o,
  output logic [5:0] ext_literal_o,
  output logic ext_add_o,
  output logic ext_sub_o,
  output logic ext_return_o,
  output logic [8*HOLD_N-1:0] hold_o
);
  // Refuse sizes that the fixed-width pointer and select logic cannot serve
  if (PTR_W != 21 || HOLD_N != 8) begin : g_bad_size
    $error("txs_exec: unsupported pointer width or holding count");
  end

  typedef enum logic [1:0] {TXS_RUN, TXS_TBL2, TXS_SKIP1, TXS_SKIP2} txs_state_t;

  // ----------------------------------------------------------------
  // Reset synchroniser and phase generator
  // ----------------------------------------------------------------
  logic rst_s1_reg, rst_s2_reg;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire rst_n = rst_s2_reg;

  logic [1:0] phase;
  logic cycle_end;
  txs_phase_gen u_phase (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .phase_o(phase),
    .cycle_end_o(cycle_end)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  txs_state_t state_reg, state_next;
  logic [15:0] ir_reg;
  logic [PTR_W-1:0] ptr_reg;
  logic [7:0] w_reg, hold_reg [HOLD_N];
  logic n_reg, z_reg, we_reg, disc_reg, ret_reg, add_reg, sub_reg;
  logic [7:0] wdata_reg;
  logic [11:0] faddr_reg;
  logic fidx_reg;
  logic [1:0] esel_reg;
  logic [5:0] elit_reg;
  logic extension_enable_bit_reg;
  logic [7:0] tlat_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire take = instr_valid_i && phase == txs_pkg::TXS_Q1 && state_reg == TXS_RUN;
  wire is_ext = extension_enable_bit_reg && instr_i[15:12] == txs_pkg::TXS_EXT_HI
      && (instr_i[11:8] == 4'h8 || instr_i[11:8] == 4'h9);
  wire [1:0] ir_mode = ir_reg[1:0];
  wire ir_xorl = ir_reg[15:8] == txs_pkg::TXS_XORL_HI;
  wire ir_xorf = ir_reg[15:10] == txs_pkg::TXS_XORF_HI;
  wire ir_tstz = ir_reg[15:9] == txs_pkg::TXS_TSTZ_HI;
  wire ir_tbl = (ir_reg & txs_pkg::TXS_TBLWR_MASK) == txs_pkg::TXS_TBLWR_BASE;
  wire ir_dest = ir_reg[9];
  wire ir_acc = ir_reg[8];
  wire [7:0] ir_f = ir_reg[7:0];
  // Bank mapping: access bank split at 0x80, indexed mode under extension
  wire ir_indexed = extension_enable_bit_reg && !ir_acc && ir_f <= txs_pkg::TXS_INDEX_LIMIT;
  wire [11:0] ir_addr = ir_acc ? {bank_select_reg_i, ir_f}
      : (ir_f[7] ? {4'hf, ir_f} : {4'h0, ir_f});
  wire next_two_word = instr_i[15:12] == txs_pkg::TXS_TWO_WORD_HI
      || instr_i[15:9] == 7'h76 || instr_i[15:12] == 4'hc;

  // Xor unit, operand from literal or file
  wire [7:0] xor_b = ir_xorl ? ir_reg[7:0] : file_data_i;
  wire [7:0] xor_res;
  wire xor_n, xor_z;
  txs_alu_xor u_xor (
    .a_i(w_reg),
    .b_i(xor_b),
    .res_o(xor_res),
    .neg_o(xor_n),
    .zero_o(xor_z)
  );

  // Pointer arithmetic
  wire [PTR_W-1:0] ptr_inc = ptr_reg + 21'h000001;
  wire [PTR_W-1:0] ptr_dec = ptr_reg - 21'h000001;
  wire [PTR_W-1:0] ptr_wr = (ir_mode == txs_pkg::TXS_PTR_PREINC) ? ptr_inc : ptr_reg;
  wire [2:0] hold_sel = ptr_wr[2:0];
  wire [PTR_W-1:0] ptr_after = (ir_mode == txs_pkg::TXS_PTR_POSTINC
      || ir_mode == txs_pkg::TXS_PTR_PREINC) ? ptr_inc
      : (ir_mode == txs_pkg::TXS_PTR_POSTDEC) ? ptr_dec : ptr_reg;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic skip_now;
  always_comb begin
    state_next = state_reg;
    skip_now = ir_tstz && file_data_i == 8'h00;
    if (cycle_end) begin
      unique case (state_reg)
        TXS_RUN: begin
          if (ir_tbl) state_next = TXS_TBL2;
          else if (skip_now) state_next = TXS_SKIP1;
        end
        TXS_TBL2: state_next = TXS_RUN;
        TXS_SKIP1: state_next = ir_reg[15:12] == 4'h0 ? TXS_RUN : TXS_SKIP2;
        TXS_SKIP2: state_next = TXS_RUN;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= TXS_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Configuration capture, resampled on every clock after reset release
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      extension_enable_bit_reg <= 1'b0;
    end else begin
      extension_enable_bit_reg <= extension_enable_bit_i;
    end
  end

  // Instruction register; in skip state holds the discarded word's class.
  // The skipped word only arrives in phase 1 of the skip cycle, so judge it there.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ir_reg <= 16'h0000;
    end else if (take) begin
      ir_reg <= instr_i;
    end else if (state_reg == TXS_SKIP1 && phase == txs_pkg::TXS_Q1 && instr_valid_i) begin
      ir_reg <= {next_two_word ? 4'hf : 4'h0, 12'h000};
    end else if (cycle_end && state_reg != TXS_TBL2 && state_next == TXS_RUN) begin
      ir_reg <= 16'h0000; // nop until next fetch
    end
  end

  // Table latch read in Q2 of the second cycle
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tlat_reg <= 8'h00;
    end else if (state_reg == TXS_TBL2 && phase == txs_pkg::TXS_Q2) begin
      tlat_reg <= table_latch_i;
    end
  end

  // Holding registers and pointer, written in Q4 of the second cycle
  for (genvar g = 0; g < HOLD_N; g++) begin : g_hold
    always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
        hold_reg[g] <= txs_pkg::TXS_HOLD_RESET;
      end else if (state_reg == TXS_TBL2 && cycle_end && hold_sel == g) begin
        hold_reg[g] <= tlat_reg;
      end
    end
    assign hold_o[8*g +: 8] = hold_reg[g];
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg <= '0;
    end else if (state_reg == TXS_TBL2 && cycle_end) begin
      ptr_reg <= ptr_after;
    end
  end

  // ----------------------------------------------------------------
  // Xor results and file access, committed in Q4
  // ----------------------------------------------------------------
  wire xor_run = state_reg == TXS_RUN && cycle_end;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      w_reg <= 8'h00;
      n_reg <= 1'b0;
      z_reg <= 1'b0;
      we_reg <= 1'b0;
      wdata_reg <= 8'h00;
    end else begin
      we_reg <= 1'b0;
      if (xor_run && (ir_xorl || (ir_xorf && !ir_dest))) begin
        w_reg <= xor_res;
      end
      if (xor_run && ir_xorf && ir_dest) begin
        we_reg <= 1'b1;
        wdata_reg <= xor_res;
      end
      if (xor_run && (ir_xorl || ir_xorf)) begin
        n_reg <= xor_n;
        z_reg <= xor_z;
      end
    end
  end

  // Address, discard and extension strobes
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      faddr_reg <= 12'h000;
      fidx_reg <= 1'b0;
      disc_reg <= 1'b0;
      add_reg <= 1'b0;
      sub_reg <= 1'b0;
      ret_reg <= 1'b0;
      esel_reg <= 2'h0;
      elit_reg <= 6'h00;
    end else begin
      faddr_reg <= ir_addr;
      fidx_reg <= ir_indexed;
      disc_reg <= state_reg != TXS_RUN && state_reg != TXS_TBL2;
      add_reg <= take && is_ext && !instr_i[8];
      sub_reg <= take && is_ext && instr_i[8];
      ret_reg <= take && is_ext && instr_i[7:6] == 2'h3;
      if (take && is_ext) begin
        esel_reg <= instr_i[7:6];
        elit_reg <= instr_i[5:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign table_pointer_o = ptr_reg;
  assign wreg_o = w_reg;
  assign flag_n_o = n_reg;
  assign flag_z_o = z_reg;
  assign file_addr_o = faddr_reg;
  assign file_indexed_o = fidx_reg;
  assign file_we_o = we_reg;
  assign file_wdata_o = wdata_reg;
  assign discard_o = disc_reg;
  assign ext_ptr_sel_o = esel_reg;
  assign ext_literal_o = elit_reg;
  assign ext_add_o = add_reg;
  assign ext_sub_o = sub_reg;
  assign ext_return_o = ret_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n);
  tbl_two_cycle_a: assert property (state_reg == TXS_RUN && cycle_end && ir_tbl
      |=> state_reg == TXS_TBL2) else $error("table write not two cycles");
  tbl_ptr_post_a: assert property (state_reg == TXS_TBL2 && cycle_end
      && ir_mode == txs_pkg::TXS_PTR_POSTINC |=> ptr_reg == $past(ptr_reg) + 21'h1)
      else $error("post-increment wrong");
  tbl_hold_a: assert property (state_reg == TXS_TBL2 && cycle_end
      |=> hold_reg[$past(hold_sel)] == $past(tlat_reg)) else $error("holding write wrong");
  tbl_keep_a: assert property (state_reg == TXS_TBL2 && cycle_end
      && ir_mode == txs_pkg::TXS_PTR_KEEP |=> $stable(ptr_reg)) else $error("pointer moved");
  skip_zero_a: assert property (state_reg == TXS_RUN && cycle_end && ir_tstz
      && file_data_i == 8'h00 |=> state_reg == TXS_SKIP1 ##4 discard_o)
      else $error("skip not taken");
  skip_len_a: assert property (state_reg == TXS_SKIP2 |-> $past(state_reg, 4) == TXS_SKIP1)
      else $error("skip length wrong");
  xor_lit_a: assert property (xor_run && ir_xorl
      |=> w_reg == ($past(w_reg) ^ $past(ir_reg[7:0])) && flag_z_o == (w_reg == 8'h00))
      else $error("literal xor wrong");
  xor_file_a: assert property (xor_run && ir_xorf && ir_dest
      |=> file_we_o && $stable(w_reg) ##1 !file_we_o) else $error("file xor wrong");
  xor_flag_a: assert property (xor_run && (ir_xorl || ir_xorf) |=> flag_n_o == $past(xor_res[7]))
      else $error("negative flag wrong");
  ext_gate_a: assert property (!extension_enable_bit_reg |=> !ext_add_o && !ext_sub_o && !file_indexed_o)
      else $error("extension active while off");
  tbl_cov_c: cover property (state_reg == TXS_TBL2 && cycle_end);
  skip2_cov_c: cover property (state_reg == TXS_SKIP2);
  xor_cov_c: cover property (file_we_o);
  ret_cov_c: cover property (ext_return_o);
endmodule : txs_exec

/* File: rtl/txs_pkg.sv */
// Package of constants for the table-write / xor / skip execution block.
// Assumes a core that feeds one fetched 16-bit word per instruction cycle.
package txs_pkg;
  // ----------------------------------------------------------------
  // Opcode patterns
  // ----------------------------------------------------------------
  localparam logic [15:0] TXS_TBLWR_BASE = 16'h000c; // low two bits = mode
  localparam logic [15:0] TXS_TBLWR_MASK = 16'hfffc;
  localparam logic [7:0] TXS_XORL_HI = 8'h0a; // literal xor high byte
  localparam logic [5:0] TXS_XORF_HI = 6'h06; // file xor top six bits
  localparam logic [6:0] TXS_TSTZ_HI = 7'h33; // test-skip top seven bits
  localparam logic [3:0] TXS_EXT_HI = 4'he; // extended literal group
  localparam logic [3:0] TXS_TWO_WORD_HI = 4'hf; // second-word marker group
  // ----------------------------------------------------------------
  // Pointer modes and widths
  // ----------------------------------------------------------------
  localparam logic [1:0] TXS_PTR_KEEP = 2'h0;
  localparam logic [1:0] TXS_PTR_POSTINC = 2'h1;
  localparam logic [1:0] TXS_PTR_POSTDEC = 2'h2;
  localparam logic [1:0] TXS_PTR_PREINC = 2'h3;
  localparam int TXS_PTR_W = 21;
  localparam int TXS_HOLD_N = 8;
  localparam logic [7:0] TXS_INDEX_LIMIT = 8'h5f; // indexed offsets up to here
  localparam logic [7:0] TXS_HOLD_RESET = 8'hff;
  // ----------------------------------------------------------------
  // Phase counts
  // ----------------------------------------------------------------
  localparam logic [1:0] TXS_Q1 = 2'h0;
  localparam logic [1:0] TXS_Q2 = 2'h1;
  localparam logic [1:0] TXS_Q3 = 2'h2;
  localparam logic [1:0] TXS_Q4 = 2'h3;
endpackage : txs_pkg

/* File: rtl/txs_phase_gen.sv */
// Four-phase instruction-cycle sequencer.
// Assumes the synchronised reset of the parent block.
`timescale 1ns/1ps
module txs_phase_gen (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Phase outputs
  output logic [1:0] phase_o,
  output logic cycle_end_o
);
  logic [1:0] phase_reg;
  // ----------------------------------------------------------------
  // Phase counter
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg <= txs_pkg::TXS_Q1;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end
  assign phase_o = phase_reg;
  assign cycle_end_o = (phase_reg == txs_pkg::TXS_Q4);
endmodule : txs_phase_gen

/* File: rtl/txs_alu_xor.sv */
// Exclusive-OR unit with negative and zero flag outputs.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
module txs_alu_xor (
  // Operands
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  // Result and flags
  output logic [7:0] res_o,
  output logic neg_o,
  output logic zero_o
);
  // Result and flags
  assign res_o = a_i ^ b_i;
  assign neg_o = res_o[7];
  assign zero_o = (res_o == 8'h00);
endmodule : txs_alu_xor

/* File: bench/table_write_xor_skip_exec_test.sv */
// Self-checking bench for the table-write / xor / skip execution unit.
// Assumes one word per four-clock slot, taken in phase 1 of each slot.
`timescale 1ns/1ps
module table_write_xor_skip_exec_test;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clock_i, rst_n_i, instr_valid_i, extension_enable_bit_i;
  logic [15:0] instr_i;
  logic [7:0] table_latch_i, file_data_i, wreg_o, file_wdata_o;
  logic [3:0] bank_select_reg_i;
  logic [20:0] table_pointer_o, exp_ptr;
  logic flag_n_o, flag_z_o, file_indexed_o, file_we_o, discard_o;
  logic ext_add_o, ext_sub_o, ext_return_o, ext_want;
  logic [11:0] file_addr_o;
  logic [1:0] ext_ptr_sel_o, sel_seen;
  logic [5:0] ext_literal_o, lit_seen;
  logic [63:0] hold_o;
  logic [7:0] exp_w, we_data;
  logic [7:0] exp_hold [8];
  logic [3:0] bsr_want;
  int error_cnt, compares, disc_cnt, we_cnt, add_cnt, sub_cnt, ret_cnt;

  // Unit under test
  txs_exec dut_u (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .extension_enable_bit_i(extension_enable_bit_i),
    .table_latch_i(table_latch_i), .file_data_i(file_data_i),
    .bank_select_reg_i(bank_select_reg_i), .table_pointer_o(table_pointer_o),
    .wreg_o(wreg_o), .flag_n_o(flag_n_o), .flag_z_o(flag_z_o),
    .file_addr_o(file_addr_o), .file_indexed_o(file_indexed_o),
    .file_we_o(file_we_o), .file_wdata_o(file_wdata_o), .discard_o(discard_o),
    .ext_ptr_sel_o(ext_ptr_sel_o), .ext_literal_o(ext_literal_o),
    .ext_add_o(ext_add_o), .ext_sub_o(ext_sub_o), .ext_return_o(ext_return_o),
    .hold_o(hold_o)
  );

  // Clock at 100 MHz
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // Counts one-clock pulses and discard clocks
  always @(posedge clock_i) begin
    if (discard_o === 1'b1) disc_cnt++;
    if (file_we_o === 1'b1) begin
      we_cnt++;
      we_data = file_wdata_o;
    end
    if (ext_add_o === 1'b1) add_cnt++;
    if (ext_sub_o === 1'b1) sub_cnt++;
    if (ext_return_o === 1'b1) ret_cnt++;
    if (ext_add_o === 1'b1 || ext_sub_o === 1'b1) begin
      sel_seen = ext_ptr_sel_o;
      lit_seen = ext_literal_o;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One instruction slot; returns at the falling edge in phase 4, before the slot's Q4 results commit
  task automatic issue(input logic [15:0] w, input logic [7:0] lat, input logic [7:0] fd);
    @(posedge clock_i);
    instr_i <= w;
    table_latch_i <= lat;
    file_data_i <= fd;
    extension_enable_bit_i <= ext_want;
    bank_select_reg_i <= bsr_want;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
  endtask : issue

  task automatic nop(input int n);
    repeat (n) issue(16'h0000, 8'h00, 8'h00);
  endtask : nop

  // Flags follow the xor result, whichever register receives it
  task automatic chk_flags(input logic [7:0] r);
    chk("neg", {63'h0, r[7]}, {63'h0, flag_n_o});
    chk("zero", {63'h0, r == 8'h00}, {63'h0, flag_z_o});
  endtask : chk_flags

  task automatic chk_w();
    chk("wreg", {56'h0, exp_w}, {56'h0, wreg_o});
    chk_flags(exp_w);
  endtask : chk_w

  task automatic print_verdict();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_xor_literal();
    logic [7:0] k [3];
    k = '{8'hb5, 8'haf, 8'h1a};
    foreach (k[i]) begin
      issue({8'h0a, k[i]}, 8'h00, 8'h00);
      nop(1);
      exp_w ^= k[i];
      chk_w();
    end
  endtask : test_xor_literal

  task automatic test_xor_file();
    issue(16'h0ab5, 8'h00, 8'h00);
    exp_w = 8'hb5;
    issue(16'h1a20, 8'h00, 8'haf);
    chk("addr access low", 64'h020, {52'h0, file_addr_o});
    nop(1);
    chk("we count", 64'd1, we_cnt);
    chk("we data", 64'h1a, {56'h0, we_data});
    chk("wreg kept on d1", {56'h0, exp_w}, {56'h0, wreg_o});
    chk_flags(8'h1a);
    bsr_want = 4'h5;
    issue(16'h1934, 8'h00, 8'h0f);
    chk("addr banked", 64'h534, {52'h0, file_addr_o});
    issue(16'h0a01, 8'h00, 8'h00);
    nop(1);
    exp_w = exp_w ^ 8'h0f ^ 8'h01;
    chk_w();
    issue(16'h1890, 8'h00, exp_w);
    chk("addr access high", 64'hf90, {52'h0, file_addr_o});
    nop(1);
    exp_w = 8'h00;
    chk_w();
    chk("we count after d0", 64'd1, we_cnt);
  endtask : test_xor_file

  task automatic test_indexed();
    ext_want = 1'b1;
    issue(16'h185f, 8'h00, 8'h00);
    chk("indexed at limit", 64'd1, {63'h0, file_indexed_o});
    issue(16'h1860, 8'h00, 8'h00);
    chk("indexed above limit", 64'd0, {63'h0, file_indexed_o});
    ext_want = 1'b0;
    issue(16'h185f, 8'h00, 8'h00);
    chk("indexed when disabled", 64'd0, {63'h0, file_indexed_o});
    nop(1);
  endtask : test_indexed

  // Latch is wrong outside the second cycle; xor in that cycle must be refused
  task automatic tbl_write(input logic [1:0] mode, input logic [7:0] lat);
    logic [63:0] exp_all;
    issue({14'h0003, mode}, 8'h5a, 8'h00);
    issue(16'h0aff, lat, 8'h00);
    issue(16'h0000, 8'ha5, 8'h00);
    if (mode == 2'h3) exp_ptr = exp_ptr + 21'h1;
    exp_hold[exp_ptr[2:0]] = lat;
    if (mode == 2'h1) exp_ptr = exp_ptr + 21'h1;
    if (mode == 2'h2) exp_ptr = exp_ptr - 21'h1;
    foreach (exp_hold[g]) exp_all[8*g+:8] = exp_hold[g];
    chk("pointer", {43'h0, exp_ptr}, {43'h0, table_pointer_o});
    chk("holding", exp_all, hold_o);
    chk("wreg kept", {56'h0, exp_w}, {56'h0, wreg_o});
  endtask : tbl_write

  task automatic skip_case(input logic [7:0] fd, input logic [15:0] w2,
                           input logic [15:0] w3, input int n_disc, input logic [7:0] mask);
    disc_cnt = 0;
    issue(16'h6620, 8'h00, fd);
    issue(w2, 8'h00, 8'h00);
    issue(w3, 8'h00, 8'h00);
    issue(16'h0a0f, 8'h00, 8'h00);
    nop(1);
    exp_w ^= mask;
    chk("skip cycles", n_disc, disc_cnt);
    chk("wreg after skip", {56'h0, exp_w}, {56'h0, wreg_o});
  endtask : skip_case

  task automatic test_ext();
    add_cnt = 0;
    sub_cnt = 0;
    ret_cnt = 0;
    ext_want = 1'b1;
    nop(1); // Config level settles before the fetch that needs it
    issue(16'he8c5, 8'h00, 8'h00);
    nop(2);
    chk("add return", 64'd1, ret_cnt);
    chk("add sel", 64'd3, {62'h0, sel_seen});
    chk("add literal", 64'd5, {58'h0, lit_seen});
    issue(16'he945, 8'h00, 8'h00);
    nop(2);
    chk("sub pulse", 64'd1, sub_cnt);
    chk("sub sel", 64'd1, {62'h0, sel_seen});
    chk("sub no return", 64'd1, ret_cnt);
    ext_want = 1'b0;
    nop(1); // Config level settles before the fetch that needs it
    issue(16'he8c5, 8'h00, 8'h00);
    nop(2);
    chk("add when disabled", 64'd1, add_cnt);
  endtask : test_ext

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    instr_valid_i = 1'b1;
    instr_i = 16'h0000;
    table_latch_i = 8'h00;
    file_data_i = 8'h00;
    bank_select_reg_i = 4'h0;
    extension_enable_bit_i = 1'b0;
    ext_want = 1'b0;
    bsr_want = 4'h0;
    exp_w = 8'h00;
    exp_ptr = 21'h0;
    foreach (exp_hold[g]) exp_hold[g] = 8'hff;
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(negedge clock_i);
    chk("hold reset", {8{8'hff}}, hold_o);
    chk("pointer reset", 64'h0, {43'h0, table_pointer_o});
    // Internal reset lifts two edges after release and phase 1 falls on the
    // third, so each slot is driven right after a phase-4 edge from here on
    @(posedge clock_i);
    test_xor_literal();
    test_xor_file();
    test_indexed();
    tbl_write(2'h1, 8'h55);
    tbl_write(2'h3, 8'h34);
    tbl_write(2'h2, 8'h12);
    tbl_write(2'h2, 8'h66);
    tbl_write(2'h2, 8'hc3);
    tbl_write(2'h0, 8'h99);
    tbl_write(2'h3, 8'he1);
    skip_case(8'h00, 16'h0af0, 16'h0a33, 4, 8'h3c);
    skip_case(8'h00, 16'hc123, 16'hf456, 8, 8'h0f);
    skip_case(8'h01, 16'h0af0, 16'h0a33, 0, 8'hcc);
    test_ext();
    print_verdict();
  end

  initial begin
    #50000;
    error_cnt++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    print_verdict();
  end
endmodule : table_write_xor_skip_exec_test
